// [pin_mux.sv]
// Transport input and auxiliary bus pin multiplexer with byte FIFO
// Summary of operation
// - Mux 00 routes pins to transport input
// - Mux 10 makes pins auxiliary data inputs
// - Mux 01, select 0 or strap low: GPIO
// - Mux 01, select 1 or strap high: smartcard
// - Alternates are GPIO bit and smartcard data
// - Byte lane bit 0 is the MSB
// - Bytes taken only while valid asserted
// - Aux data bit 0, address bit 9 MSB
// - Disk mode puts strobes on address 14, 15
// - Card mode without disk mode drives card address on 17-21
// - Address 9 pin carries chip select five
`include "pin_mux_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic push, pop;

  // Full when pointers differ only in the wrap bit; depth must be a power of two
  assign o_in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_reg != rd_reg;
  assign o_out_data = mem_reg[rd_reg[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= i_in_data;
    end
  end
endmodule

module pin_mux (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic [`PM_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic [0:7] I_SHARED_DATA_PIN,
  input wire logic I_SHARED_START_PIN,
  input wire logic I_SHARED_CLOCK_PIN,
  input wire logic I_SHARED_VALID_PIN,
  output logic [9:21] O_AUX_BUS_ADDR
);
  // Pin synchronisers: stage one is read only by stage two
  logic [0:7] data_s1_reg, data_s2_reg;
  logic start_s1_reg, start_s2_reg, valid_s1_reg, valid_s2_reg;
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      data_s1_reg <= '0;
      data_s2_reg <= '0;
      start_s1_reg <= 1'b0;
      start_s2_reg <= 1'b0;
      valid_s1_reg <= 1'b0;
      valid_s2_reg <= 1'b0;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end else begin
      data_s1_reg <= I_SHARED_DATA_PIN;
      data_s2_reg <= data_s1_reg;
      start_s1_reg <= I_SHARED_START_PIN;
      start_s2_reg <= start_s1_reg;
      valid_s1_reg <= I_SHARED_VALID_PIN;
      valid_s2_reg <= valid_s1_reg;
      clk_s1_reg <= I_SHARED_CLOCK_PIN;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  // Register state
  pin_mux_pkg::pin_func_e pf_reg, pf_next;
  pin_mux_pkg::out_ctrl_s ctrl_reg, ctrl_next;
  logic alt_reg, alt_next;
  logic [12:0] aux_addr_reg, aux_addr_next;
  logic ovf_reg, ovf_next, align_reg, align_next;
  logic strap_reg, strap_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic [7:0] pkt_cnt_reg, pkt_cnt_next;
  logic [31:0] rdata_next;
  logic [9:21] addr_next;

  // Transport capture
  logic ts_edge, ts_take, fifo_ready, fifo_valid, fifo_pop;
  logic [7:0] ts_in_byte;
  logic [7:0] aux_bus_data;
  logic simple_gpio_bit, smartcard_data_io;
  pin_mux_pkg::ts_word_s ts_word, fifo_word;
  logic wr_stat, rd_data;

  // Pin 0 lands in bit 7, so lane bit 0 is the byte's MSB
  assign ts_in_byte = data_s2_reg;
  assign ts_edge = clk_s2_reg && !clk_s3_reg;
  assign ts_take = ts_edge && valid_s2_reg && (pf_reg == pin_mux_pkg::PF_TS);
  assign ts_word = '{start: start_s2_reg, data: ts_in_byte};
  // Each function sees the pins only while selected
  assign aux_bus_data = (pf_reg == pin_mux_pkg::PF_AUX) ? data_s2_reg : 8'h00;
  assign simple_gpio_bit = (pf_reg == pin_mux_pkg::PF_ALT) && !alt_reg
    && data_s2_reg[0];
  assign smartcard_data_io = (pf_reg == pin_mux_pkg::PF_ALT) && alt_reg
    && data_s2_reg[0];
  assign wr_stat = I_WR && (I_ADDR == `PM_OFF_STATUS);
  assign rd_data = I_RD && (I_ADDR == `PM_OFF_TS_DATA);
  assign fifo_pop = rd_data;

  byte_fifo #(
    .WIDTH(`PM_FIFO_WIDTH),
    .DEPTH(`PM_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_in_valid(ts_take),
    .o_in_ready(fifo_ready),
    .i_in_data(ts_word),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_word)
  );

  always_comb begin
    pf_next = pf_reg;
    alt_next = alt_reg;
    ctrl_next = ctrl_reg;
    aux_addr_next = aux_addr_reg;
    strap_next = strap_reg;
    strap_cnt_next = strap_cnt_reg;
    pkt_cnt_next = pkt_cnt_reg;
    // Strap waits out the synchroniser before the data 7 pin is trusted
    if (strap_cnt_reg != `PM_STRAP_WAIT) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_next == `PM_STRAP_WAIT) begin
        strap_next = data_s2_reg[7];
        alt_next = data_s2_reg[7];
      end
    end
    if (I_WR) begin
      unique case (I_ADDR)
        `PM_OFF_PIN_MUX: pf_next = pin_mux_pkg::pin_func_e'(I_WDATA[`PM_PF_HI:`PM_PF_LO]);
        `PM_OFF_ALT_SEL: alt_next = I_WDATA[`PM_ALT_BIT];
        `PM_OFF_OUT_CTRL: ctrl_next = pin_mux_pkg::out_ctrl_s'(I_WDATA[12:0]);
        `PM_OFF_AUX_ADDR: aux_addr_next = I_WDATA[12:0];
        default: ;
      endcase
    end
    // Count bytes in the packet; a start restarts the count
    if (ts_take) begin
      if (start_s2_reg) begin
        pkt_cnt_next = 8'h01;
      end else if (pkt_cnt_reg == `PM_PKT_LEN) begin
        pkt_cnt_next = 8'h01;
      end else begin
        pkt_cnt_next = pkt_cnt_reg + 8'h01;
      end
    end
    // Sticky flags: a new event wins over a clear in the same cycle
    ovf_next = (ovf_reg && !(wr_stat && I_WDATA[`PM_ST_OVF_BIT])) || (ts_take && !fifo_ready);
    align_next = (align_reg && !(wr_stat && I_WDATA[`PM_ST_ALIGN_BIT]))
      || (ts_take && (start_s2_reg != (pkt_cnt_reg == `PM_PKT_LEN))
      && (pkt_cnt_reg != 8'h00));
  end

  // Read data stands for exactly the cycle after the strobe
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (I_RD) begin
      unique case (I_ADDR)
        `PM_OFF_PIN_MUX: rdata_next[`PM_PF_HI:`PM_PF_LO] = pf_reg;
        `PM_OFF_ALT_SEL: rdata_next[`PM_ALT_BIT] = alt_reg;
        `PM_OFF_OUT_CTRL: rdata_next[12:0] = ctrl_reg;
        `PM_OFF_AUX_ADDR: rdata_next[12:0] = aux_addr_reg;
        `PM_OFF_STATUS: rdata_next[15:0] = {aux_bus_data, 2'b00, smartcard_data_io,
          simple_gpio_bit, strap_reg, align_reg, ovf_reg, fifo_valid};
        `PM_OFF_TS_DATA: rdata_next[9:0] = {fifo_valid, fifo_valid ? fifo_word : 9'h000};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Address pins: plain address unless an alternate claims the pin
  always_comb begin
    addr_next = aux_addr_reg;
    if (ctrl_reg.cs5_mode) begin
      addr_next[9] = ctrl_reg.cs5_n;
    end
    if (ctrl_reg.disk_mode) begin
      addr_next[14] = ctrl_reg.disk_wr_n;
      addr_next[15] = ctrl_reg.disk_rd_n;
    end else if (ctrl_reg.card_mode) begin
      addr_next[14] = ctrl_reg.card_wr_n;
      addr_next[15] = ctrl_reg.card_rd_n;
      addr_next[17:21] = ctrl_reg.card_addr;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pf_reg <= pin_mux_pkg::PF_TS;
      alt_reg <= 1'b0;
      ctrl_reg <= `PM_OUT_CTRL_RST;
      aux_addr_reg <= 13'h0000;
      ovf_reg <= 1'b0;
      align_reg <= 1'b0;
      strap_reg <= 1'b0;
      strap_cnt_reg <= 2'h0;
      pkt_cnt_reg <= 8'h00;
      O_RDATA <= 32'h0000_0000;
      O_AUX_BUS_ADDR <= 13'h0000;
    end else begin
      pf_reg <= pf_next;
      alt_reg <= alt_next;
      ctrl_reg <= ctrl_next;
      aux_addr_reg <= aux_addr_next;
      ovf_reg <= ovf_next;
      align_reg <= align_next;
      strap_reg <= strap_next;
      strap_cnt_reg <= strap_cnt_next;
      pkt_cnt_reg <= pkt_cnt_next;
      O_RDATA <= rdata_next;
      O_AUX_BUS_ADDR <= addr_next;
    end
  end

  ts_mode_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ts_take |-> pf_reg == pin_mux_pkg::PF_TS)
    else $error("byte taken outside transport mode");
  ts_valid_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ts_take |-> valid_s2_reg && clk_s2_reg && !clk_s3_reg)
    else $error("byte taken without valid on a clock edge");
  byte_order_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ts_take |-> ts_word.data[7] == data_s2_reg[0] && ts_word.data[0] == data_s2_reg[7])
    else $error("byte lane order wrong");
  aux_data_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_RD && I_ADDR == `PM_OFF_STATUS && pf_reg != pin_mux_pkg::PF_AUX
    ##1 pf_reg != pin_mux_pkg::PF_AUX |-> O_RDATA[15:8] == 8'h00)
    else $error("aux data visible outside aux mode");
  alt_select_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    simple_gpio_bit |-> !alt_reg && !smartcard_data_io)
    else $error("alternate functions overlap");
  gpio_follow_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    pf_reg == pin_mux_pkg::PF_ALT && !alt_reg |-> simple_gpio_bit == data_s2_reg[0])
    else $error("gpio bit does not follow shared pin 0");
  aux_mask_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    pf_reg != pin_mux_pkg::PF_AUX |-> aux_bus_data == 8'h00)
    else $error("aux data seen while not selected");
  strap_load_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    strap_cnt_reg == 2'h2 && !(I_WR && I_ADDR == `PM_OFF_ALT_SEL)
    |=> alt_reg == $past(data_s2_reg[7]))
    else $error("strap not loaded into alternate select");
  disk_strobe_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ctrl_reg.disk_mode |=> O_AUX_BUS_ADDR[14] == $past(ctrl_reg.disk_wr_n)
    && O_AUX_BUS_ADDR[15] == $past(ctrl_reg.disk_rd_n))
    else $error("disk strobes not on address 14 and 15");
  card_addr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ctrl_reg.card_mode && !ctrl_reg.disk_mode |=>
    O_AUX_BUS_ADDR[17:21] == $past(ctrl_reg.card_addr))
    else $error("card address not on pins 17 to 21");
  cs5_pin_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ctrl_reg.cs5_mode |=> O_AUX_BUS_ADDR[9] == $past(ctrl_reg.cs5_n))
    else $error("chip select five not on address 9");
  pkt_align_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ts_take && start_s2_reg |=> pkt_cnt_reg == 8'h01)
    else $error("packet start does not realign count");
endmodule

`default_nettype wire

// [pin_mux_consts.svh]
// Register offsets, field positions, reset values and timing counts for the pin mux
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
`define PM_ADDR_W 8
`define PM_OFF_PIN_MUX 8'h00
`define PM_OFF_ALT_SEL 8'h04
`define PM_OFF_OUT_CTRL 8'h08
`define PM_OFF_AUX_ADDR 8'h0C
`define PM_OFF_STATUS 8'h10
`define PM_OFF_TS_DATA 8'h14
`define PM_PF_HI 11
`define PM_PF_LO 10
`define PM_ALT_BIT 2
`define PM_OUT_CTRL_RST 13'h00F8
`define PM_ST_OVF_BIT 1
`define PM_ST_ALIGN_BIT 2
`define PM_PKT_LEN 8'hBC
`define PM_STRAP_WAIT 2'h3
`define PM_FIFO_DEPTH 8
`define PM_FIFO_WIDTH 9
`endif

// [pin_mux_pkg.sv]
// Types shared by the pin mux
package pin_mux_pkg;
  typedef enum logic [1:0] {
    PF_TS = 2'b00,
    PF_ALT = 2'b01,
    PF_AUX = 2'b10,
    PF_RSV = 2'b11
  } pin_func_e;
  typedef struct packed {
    logic start;
    logic [7:0] data;
  } ts_word_s;
  typedef struct packed {
    logic [4:0] card_addr;
    logic card_rd_n;
    logic card_wr_n;
    logic disk_rd_n;
    logic disk_wr_n;
    logic cs5_n;
    logic cs5_mode;
    logic card_mode;
    logic disk_mode;
  } out_ctrl_s;
endpackage

// [ts_source_model.sv]
// Packet source model driving the shared transport pins
`timescale 1ns/100ps
`default_nettype none
module ts_source_model (
  output logic [0:7] o_data,
  output logic o_start,
  output logic o_clk,
  output logic o_valid
);
  initial begin
    o_data = 8'h81;
    o_start = 1'b0;
    o_clk = 1'b0;
    o_valid = 1'b0;
  end
  // One link clock period per byte; the clock stands still between calls
  task automatic send(input logic [7:0] b, input logic s, input logic v);
    o_data <= b;
    o_start <= s;
    o_valid <= v;
    #62.5 o_clk = 1'b1;
    #62.5 o_clk = 1'b0;
  endtask
  // Released lane shows the inverse so a stale byte cannot pass as held
  task automatic idle();
    o_data <= ~o_data;
    o_start <= 1'b0;
    o_valid <= 1'b0;
  endtask
  task automatic hold(input logic [7:0] b);
    o_data <= b;
  endtask
endmodule
`default_nettype wire

// [pin_mux_tb.sv]
// Self-checking bench for the pin mux
`timescale 1ns/100ps
`default_nettype none
module pin_mux_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [0:7] pins;
  logic pstart;
  logic pclk;
  logic pvalid;
  logic [9:21] aux;
  int num_errors = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  ts_source_model u_src (.o_data(pins), .o_start(pstart), .o_clk(pclk), .o_valid(pvalid));
  pin_mux u_dut (.I_CLOCK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SHARED_DATA_PIN(pins),
    .I_SHARED_START_PIN(pstart), .I_SHARED_CLOCK_PIN(pclk),
    .I_SHARED_VALID_PIN(pvalid), .O_AUX_BUS_ADDR(aux));
  task automatic report_and_stop();
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic aux_chk(input logic [31:0] ctrl, input logic [12:0] exp);
    wr_reg(8'h08, ctrl);
    @(posedge clk);
    #1 chk({19'h0, aux}, {19'h0, exp});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h4);
    rd_chk(8'h08, 32'hF8);
    rd_chk(8'h10, 32'h8);
    wr_reg(8'h18, 32'hFFFF);
    rd_chk(8'h18, 32'h0);
    wr_reg(8'h00, 32'h400);
    rd_chk(8'h10, 32'h28);
    wr_reg(8'h04, 32'h0);
    rd_chk(8'h10, 32'h18);
    // Valid byte while in aux data mode must not reach the FIFO
    wr_reg(8'h00, 32'h800);
    u_src.send(8'h12, 1'b1, 1'b1);
    u_src.hold(8'hA5);
    repeat (8) @(posedge clk);
    rd_chk(8'h10, 32'hA508);
    wr_reg(8'h00, 32'h0);
    for (int i = 0; i < 10; i++) begin
      u_src.send(8'hA0 + i[7:0], i == 0, i != 3);
    end
    u_src.idle();
    repeat (8) @(posedge clk);
    rd_chk(8'h10, 32'hB);
    for (int i = 0; i < 9; i++) begin
      if (i != 3) begin
        rd_chk(8'h14, {22'h0, 1'b1, i == 0, 8'hA0 + i[7:0]});
      end
    end
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h10, 32'hA);
    wr_reg(8'h10, 32'h2);
    rd_chk(8'h10, 32'h8);
    u_src.send(8'h77, 1'b1, 1'b1);
    u_src.idle();
    repeat (8) @(posedge clk);
    rd_chk(8'h10, 32'hD);
    rd_chk(8'h14, 32'h377);
    wr_reg(8'h10, 32'h4);
    rd_chk(8'h10, 32'h8);
    wr_reg(8'h0C, 32'h1ABC);
    aux_chk(32'hF8, 13'h1ABC);
    aux_chk(32'hF4, 13'h0ABC);
    aux_chk(32'hE9, 13'h1A7C);
    aux_chk(32'h13BA, 13'h1A73);
    // Second reset with pin 7 low: strap must pick the GPIO alternate
    u_src.hold(8'h00);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({19'h0, aux}, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h10, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
